// *** amd_decoder.sv ***
/*
  Fetches one instruction, applies any prebyte, fetches the address and pointer
  bytes, and delivers the effective address, branch target and length.
  Assumes a byte memory on the same clock that answers each held request
  with an acknowledge and data in the same cycle.
*/
// Contract
// - Short indexed: one offset byte plus index, reaching 00 to 1FE.
// - Long indexed: two offset bytes after opcode plus index, full 64K reach.
// - Indirect: read pointer address after opcode, then fetch pointer from memory.
// - Short indirect: byte pointer, operand address limited to 00 to FF.
// - Long indirect forms: one pointer-address byte selects a word pointer.
// - Indirect-indexed address is unsigned sum of index and fetched pointer.
// - Short indirect-indexed: byte pointer plus index, reaching 00 to 1FE.
// - ALU, load and compare opcodes have long and short memory forms.
// - Read-modify-write, bit, call and jump opcodes have short forms only; the code also gives jump and call rows long direct and long indexed forms.
// - Relative mode adds sign-extended 8-bit offset to the program counter.
// - Direct relative offset follows opcode; indirect relative reads it from memory.
// - The decoder covers the 63-instruction set in 13 groups.
// - Three prebytes alter how the immediately following opcode is read.
// - Prefixed layout: prebyte, opcode, then zero to two address bytes.
// - Prebyte 90 swaps first index register for second in plain modes.
// - Prebyte 92 turns direct modes and first-index indexed into indirect ones.
// - Prebyte 91 moves first-index indirect-indexed onto the second index.
// - Indexed address is unsigned sum of chosen index and offset.
// - Short direct uses one byte for 00 to FF; long direct two.
// - Undefined byte raises reset; unauthorised prebyte pairing does not.
module amd_decoder (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 start,
  input  wire logic [15:0]          start_pc,
  input  wire logic [7:0]           index_x,
  input  wire logic [7:0]           index_y,
  output logic                      ready,
  output logic                      mem_req,
  output logic [15:0]               mem_addr,
  input  wire logic                 mem_ack,
  input  wire logic [7:0]           mem_rdata,
  output logic                      done,
  output amd_pkg::amd_result_t      result,
  output logic                      illegal_reset
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OPC  = 3'b001,
    S_DEC  = 3'b010,
    S_ARG  = 3'b011,
    S_PTR  = 3'b100,
    S_REL  = 3'b101,
    S_DONE = 3'b110
  } amd_state_t;

  amd_state_t           state_q;
  logic [15:0]          pc_q;
  logic [15:0]          first_pc_q;
  logic [15:0]          addr_q;
  logic [7:0]           x_q;
  logic [7:0]           y_q;
  logic                 pre_valid_q;
  logic [7:0]           pre_q;
  logic [7:0]           opc_q;
  logic [15:0]          arg_q;
  logic [15:0]          ptr_q;
  logic [7:0]           rel_q;
  logic [1:0]           cnt_q;
  logic                 done_q;
  logic                 ill_q;
  amd_pkg::amd_result_t res_q;

  amd_pkg::amd_mode_t   mode;
  logic                 use_y;
  logic                 unauth;
  logic                 illegal;
  logic [1:0]           n_arg;
  logic [1:0]           n_ptr;
  logic                 has_rel;
  logic                 is_prebyte;
  logic [15:0]          idx;
  logic [15:0]          ea;
  logic [15:0]          target;
  logic [7:0]           rel_byte;
  logic [15:0]          pc_inc;

  // The mode is fixed from prebyte and opcode before any operand byte is read.
  amd_mode_table u_table (
    .pre_valid (pre_valid_q),
    .prebyte   (pre_q),
    .opcode    (opc_q),
    .mode      (mode),
    .use_y     (use_y),
    .unauth    (unauth),
    .illegal   (illegal),
    .n_arg     (n_arg),
    .n_ptr     (n_ptr),
    .has_rel   (has_rel)
  );

  assign is_prebyte = (mem_rdata == amd_pkg::PRE_SECOND_INDEX) ||
                      (mem_rdata == amd_pkg::PRE_INDIRECT) ||
                      (mem_rdata == amd_pkg::PRE_INDIRECT_SECND);
  assign pc_inc     = pc_q + 16'h0001;
  assign idx        = {8'h00, (use_y ? y_q : x_q)};

  assign ready         = (state_q == S_IDLE);
  assign mem_req       = (state_q == S_OPC) || (state_q == S_ARG) ||
                         (state_q == S_PTR) || (state_q == S_REL);
  assign mem_addr      = addr_q;
  assign done          = done_q;
  assign result        = res_q;
  assign illegal_reset = ill_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      cnt_q   <= 2'd0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q <= S_OPC;
          end
        end
        S_OPC: begin
          // A second prebyte-valued byte is taken as the opcode itself.
          if (mem_ack && !(is_prebyte && !pre_valid_q)) begin
            state_q <= S_DEC;
          end
        end
        S_DEC: begin
          if (illegal) begin
            state_q <= S_IDLE;
          end else if (n_arg != 2'd0) begin
            state_q <= S_ARG;
            cnt_q   <= n_arg;
          end else begin
            state_q <= S_DONE;
          end
        end
        S_ARG: begin
          if (mem_ack) begin
            cnt_q <= cnt_q - 2'd1;
            if (cnt_q == 2'd1) begin
              if (n_ptr != 2'd0) begin
                state_q <= S_PTR;
                cnt_q   <= n_ptr;
              end else if (has_rel) begin
                state_q <= S_REL;
              end else begin
                state_q <= S_DONE;
              end
            end
          end
        end
        S_PTR: begin
          if (mem_ack) begin
            cnt_q <= cnt_q - 2'd1;
            if (cnt_q == 2'd1) begin
              state_q <= has_rel ? S_REL : S_DONE;
            end
          end
        end
        S_REL: begin
          if (mem_ack) begin
            state_q <= S_DONE;
          end
        end
        S_DONE:  state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Fetch pointer and address register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_q       <= amd_pkg::RST_ADDR;
      first_pc_q <= amd_pkg::RST_ADDR;
      addr_q     <= amd_pkg::RST_ADDR;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            pc_q       <= start_pc;
            first_pc_q <= start_pc;
            addr_q     <= start_pc;
          end
        end
        S_OPC, S_REL: begin
          if (mem_ack) begin
            pc_q   <= pc_inc;
            addr_q <= pc_inc;
          end
        end
        S_DEC: addr_q <= pc_q;
        S_ARG: begin
          if (mem_ack) begin
            pc_q <= pc_inc;
            if ((cnt_q == 2'd1) && (n_ptr != 2'd0)) begin
              addr_q <= {8'h00, mem_rdata};
            end else begin
              addr_q <= pc_inc;
            end
          end
        end
        S_PTR: begin
          if (mem_ack) begin
            // The word pointer sits high byte first at the pointer address.
            addr_q <= (cnt_q == 2'd1) ? pc_q : addr_q + 16'h0001;
          end
        end
        default: addr_q <= addr_q;
      endcase
    end
  end

  // Instruction bytes as they arrive.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_valid_q <= 1'b0;
      pre_q       <= amd_pkg::RST_BYTE;
      opc_q       <= amd_pkg::RST_BYTE;
      arg_q       <= amd_pkg::RST_ADDR;
      ptr_q       <= amd_pkg::RST_ADDR;
      rel_q       <= amd_pkg::RST_BYTE;
      x_q         <= amd_pkg::RST_BYTE;
      y_q         <= amd_pkg::RST_BYTE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            pre_valid_q <= 1'b0;
            pre_q       <= amd_pkg::RST_BYTE;
            arg_q       <= amd_pkg::RST_ADDR;
            ptr_q       <= amd_pkg::RST_ADDR;
            rel_q       <= amd_pkg::RST_BYTE;
            x_q         <= index_x;
            y_q         <= index_y;
          end
        end
        S_OPC: begin
          if (mem_ack) begin
            if (is_prebyte && !pre_valid_q) begin
              pre_valid_q <= 1'b1;
              pre_q       <= mem_rdata;
            end else begin
              opc_q <= mem_rdata;
            end
          end
        end
        S_ARG: begin
          if (mem_ack) begin
            arg_q <= {arg_q[7:0], mem_rdata};
          end
        end
        S_PTR: begin
          if (mem_ack) begin
            ptr_q <= {ptr_q[7:0], mem_rdata};
          end
        end
        S_REL: begin
          if (mem_ack) begin
            rel_q <= mem_rdata;
          end
        end
        default: rel_q <= rel_q;
      endcase
    end
  end

  // Effective address, one form per mode.
  always_comb begin
    case (mode)
      amd_pkg::AM_IMM:   ea = first_pc_q + {13'h0000, pc_q[2:0] - first_pc_q[2:0]} - 16'h0001;
      amd_pkg::AM_DIR_S: ea = {8'h00, arg_q[7:0]};
      amd_pkg::AM_DIR_L: ea = arg_q;
      amd_pkg::AM_IX0:   ea = idx;
      amd_pkg::AM_IX_S:  ea = idx + {8'h00, arg_q[7:0]};
      amd_pkg::AM_IX_L:  ea = idx + arg_q;
      amd_pkg::AM_IND_S: ea = {8'h00, ptr_q[7:0]};
      amd_pkg::AM_IND_L: ea = ptr_q;
      amd_pkg::AM_IIX_S: ea = idx + {8'h00, ptr_q[7:0]};
      amd_pkg::AM_IIX_L: ea = idx + ptr_q;
      amd_pkg::AM_BIT_D, amd_pkg::AM_BTJ_D: ea = {8'h00, arg_q[7:0]};
      amd_pkg::AM_BIT_I, amd_pkg::AM_BTJ_I: ea = {8'h00, ptr_q[7:0]};
      default:           ea = amd_pkg::RST_ADDR;
    endcase
  end

  // Branch offset: in the opcode stream, behind a pointer, or after a bit address.
  always_comb begin
    case (mode)
      amd_pkg::AM_REL_D: rel_byte = arg_q[7:0];
      amd_pkg::AM_REL_I: rel_byte = ptr_q[7:0];
      amd_pkg::AM_BTJ_D, amd_pkg::AM_BTJ_I: rel_byte = rel_q;
      default:           rel_byte = amd_pkg::RST_BYTE;
    endcase
    target = pc_q + {{8{rel_byte[7]}}, rel_byte};
  end

  // Result and reset pulse; the result holds until the next legal instruction ends.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      ill_q  <= 1'b0;
      res_q  <= '0;
    end else begin
      done_q <= (state_q == S_DONE);
      ill_q  <= (state_q == S_DEC) && illegal;
      if (state_q == S_DONE) begin
        res_q.mode    <= mode;
        res_q.use_y   <= use_y;
        res_q.unauth  <= unauth;
        res_q.length  <= pc_q[2:0] - first_pc_q[2:0];
        res_q.prebyte <= pre_valid_q ? pre_q : amd_pkg::RST_BYTE;
        res_q.opcode  <= opc_q;
        res_q.ea      <= ea;
        res_q.target  <= target;
        res_q.data    <= (mode == amd_pkg::AM_IMM) ? arg_q[7:0] : rel_byte;
      end
    end
  end

endmodule

// *** amd_pkg.sv ***
/*
  Shared constants and types for the addressing mode and prebyte decoder.
  Assumes an 8-bit instruction stream with a 16-bit byte address space.
*/
package amd_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Prebyte values that alter the following opcode.
  localparam logic [7:0] PRE_SECOND_INDEX   = 8'h90;
  localparam logic [7:0] PRE_INDIRECT       = 8'h92;
  localparam logic [7:0] PRE_INDIRECT_SECND = 8'h91;

  // Opcode column and row fields.
  localparam int unsigned COL_LSB = 4;
  localparam int unsigned ROW_LSB = 0;

  // Opcode columns that carry a mode of their own.
  localparam logic [3:0] COL_BTJ_DIR = 4'h0;
  localparam logic [3:0] COL_BIT_DIR = 4'h1;
  localparam logic [3:0] COL_REL_DIR = 4'h2;
  localparam logic [3:0] COL_RMW_DIR = 4'h3;
  localparam logic [3:0] COL_RMW_A   = 4'h4;
  localparam logic [3:0] COL_RMW_X   = 4'h5;
  localparam logic [3:0] COL_RMW_IXS = 4'h6;
  localparam logic [3:0] COL_RMW_IX0 = 4'h7;
  localparam logic [3:0] COL_INH_8   = 4'h8;
  localparam logic [3:0] COL_INH_9   = 4'h9;
  localparam logic [3:0] COL_IMM     = 4'ha;
  localparam logic [3:0] COL_DIR_S   = 4'hb;
  localparam logic [3:0] COL_DIR_L   = 4'hc;
  localparam logic [3:0] COL_IX_L    = 4'hd;
  localparam logic [3:0] COL_IX_S    = 4'he;
  localparam logic [3:0] COL_IX0     = 4'hf;

  // Rows with a special meaning inside some columns.
  localparam logic [3:0] ROW_HOLE_A  = 4'h1;
  localparam logic [3:0] ROW_HOLE_B  = 4'h2;
  localparam logic [3:0] ROW_HOLE_C  = 4'h5;
  localparam logic [3:0] ROW_HOLE_D  = 4'hb;
  localparam logic [3:0] ROW_JUMP    = 4'hc;
  localparam logic [3:0] ROW_CALL    = 4'hd;
  localparam logic [3:0] ROW_STORE   = 4'h7;
  localparam logic [7:0] OPC_MULTIPLY = 8'h42;

  // Reset values.
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  typedef enum logic [4:0] {
    AM_INH   = 5'h00,
    AM_IMM   = 5'h01,
    AM_DIR_S = 5'h02,
    AM_DIR_L = 5'h03,
    AM_IX0   = 5'h04,
    AM_IX_S  = 5'h05,
    AM_IX_L  = 5'h06,
    AM_IND_S = 5'h07,
    AM_IND_L = 5'h08,
    AM_IIX_S = 5'h09,
    AM_IIX_L = 5'h0a,
    AM_REL_D = 5'h0b,
    AM_REL_I = 5'h0c,
    AM_BIT_D = 5'h0d,
    AM_BIT_I = 5'h0e,
    AM_BTJ_D = 5'h0f,
    AM_BTJ_I = 5'h10
  } amd_mode_t;

  typedef struct packed {
    amd_mode_t   mode;
    logic        use_y;
    logic        unauth;
    logic [2:0]  length;
    logic [7:0]  prebyte;
    logic [7:0]  opcode;
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0]  data;
  } amd_result_t;

endpackage

// *** amd_mode_table.sv ***
/*
  Combinational table from prebyte and opcode to addressing mode and byte counts.
  Assumes prebyte and opcode are held stable by the caller while it is read.
*/
module amd_mode_table (
  input  wire logic              pre_valid,
  input  wire logic [7:0]        prebyte,
  input  wire logic [7:0]        opcode,
  output amd_pkg::amd_mode_t     mode,
  output logic                   use_y,
  output logic                   unauth,
  output logic                   illegal,
  output logic [1:0]             n_arg,
  output logic [1:0]             n_ptr,
  output logic                   has_rel
);

  logic [3:0]         col;
  logic [3:0]         row;
  amd_pkg::amd_mode_t base;

  assign col = opcode[amd_pkg::COL_LSB +: 4];
  assign row = opcode[amd_pkg::ROW_LSB +: 4];

  always_comb begin
    base    = amd_pkg::AM_INH;
    illegal = 1'b0;
    case (col)
      amd_pkg::COL_BTJ_DIR: base = amd_pkg::AM_BTJ_D;
      amd_pkg::COL_BIT_DIR: base = amd_pkg::AM_BIT_D;
      amd_pkg::COL_REL_DIR: base = amd_pkg::AM_REL_D;
      amd_pkg::COL_RMW_DIR: base = amd_pkg::AM_DIR_S;
      amd_pkg::COL_RMW_IXS: base = amd_pkg::AM_IX_S;
      amd_pkg::COL_RMW_IX0: base = amd_pkg::AM_IX0;
      amd_pkg::COL_IMM: begin
        base = (row == amd_pkg::ROW_CALL) ? amd_pkg::AM_REL_D : amd_pkg::AM_IMM;
        illegal = (row == amd_pkg::ROW_JUMP) || (row == amd_pkg::ROW_STORE);
      end
      amd_pkg::COL_DIR_S: base = amd_pkg::AM_DIR_S;
      amd_pkg::COL_DIR_L: base = amd_pkg::AM_DIR_L;
      amd_pkg::COL_IX_L:  base = amd_pkg::AM_IX_L;
      amd_pkg::COL_IX_S:  base = amd_pkg::AM_IX_S;
      amd_pkg::COL_IX0:   base = amd_pkg::AM_IX0;
      default:            base = amd_pkg::AM_INH;
    endcase
    // Holes in the read-modify-write columns are bytes with no meaning at all.
    if ((col >= amd_pkg::COL_RMW_DIR) && (col <= amd_pkg::COL_RMW_IX0)) begin
      if ((row == amd_pkg::ROW_HOLE_A) || (row == amd_pkg::ROW_HOLE_C) ||
          (row == amd_pkg::ROW_HOLE_D) ||
          ((row == amd_pkg::ROW_HOLE_B) && (opcode != amd_pkg::OPC_MULTIPLY))) begin
        illegal = 1'b1;
      end
    end
  end

  always_comb begin
    mode   = base;
    use_y  = 1'b0;
    unauth = 1'b0;
    if (pre_valid) begin
      case (prebyte)
        amd_pkg::PRE_SECOND_INDEX: begin
          case (base)
            amd_pkg::AM_INH, amd_pkg::AM_IMM, amd_pkg::AM_DIR_S, amd_pkg::AM_DIR_L,
            amd_pkg::AM_IX0, amd_pkg::AM_IX_S, amd_pkg::AM_IX_L: use_y = 1'b1;
            default: unauth = 1'b1;
          endcase
        end
        amd_pkg::PRE_INDIRECT: begin
          case (base)
            amd_pkg::AM_DIR_S: mode = amd_pkg::AM_IND_S;
            amd_pkg::AM_DIR_L: mode = amd_pkg::AM_IND_L;
            amd_pkg::AM_BIT_D: mode = amd_pkg::AM_BIT_I;
            amd_pkg::AM_BTJ_D: mode = amd_pkg::AM_BTJ_I;
            amd_pkg::AM_REL_D: mode = amd_pkg::AM_REL_I;
            amd_pkg::AM_IX_S:  mode = amd_pkg::AM_IIX_S;
            amd_pkg::AM_IX_L:  mode = amd_pkg::AM_IIX_L;
            default:           unauth = 1'b1;
          endcase
        end
        amd_pkg::PRE_INDIRECT_SECND: begin
          case (base)
            amd_pkg::AM_IX_S: begin
              mode  = amd_pkg::AM_IIX_S;
              use_y = 1'b1;
            end
            amd_pkg::AM_IX_L: begin
              mode  = amd_pkg::AM_IIX_L;
              use_y = 1'b1;
            end
            default: unauth = 1'b1;
          endcase
        end
        default: unauth = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (mode)
      amd_pkg::AM_INH, amd_pkg::AM_IX0:   n_arg = 2'd0;
      amd_pkg::AM_DIR_L, amd_pkg::AM_IX_L: n_arg = 2'd2;
      default:                             n_arg = 2'd1;
    endcase
    case (mode)
      amd_pkg::AM_IND_S, amd_pkg::AM_IIX_S, amd_pkg::AM_REL_I,
      amd_pkg::AM_BIT_I, amd_pkg::AM_BTJ_I: n_ptr = 2'd1;
      amd_pkg::AM_IND_L, amd_pkg::AM_IIX_L: n_ptr = 2'd2;
      default:                              n_ptr = 2'd0;
    endcase
    has_rel = (mode == amd_pkg::AM_BTJ_D) || (mode == amd_pkg::AM_BTJ_I);
  end

endmodule

// *** amd_decoder_sva.sv ***
/*
  Concurrent checks on the ports of the addressing mode and prebyte decoder.
  Assumes the memory answers every fetch within two stall cycles.
*/
module amd_decoder_sva (
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 start,
  input wire logic [15:0]          start_pc,
  input wire logic [7:0]           index_x,
  input wire logic [7:0]           index_y,
  input wire logic                 ready,
  input wire logic                 mem_req,
  input wire logic [15:0]          mem_addr,
  input wire logic                 mem_ack,
  input wire logic [7:0]           mem_rdata,
  input wire logic                 done,
  input wire amd_pkg::amd_result_t result,
  input wire logic                 illegal_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [15:0] pc_q;
  logic [15:0] rel_base;
  // The start address is kept here so that the branch target can be rebuilt.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pc_q <= 16'h0000;
    else if (ready && start) pc_q <= start_pc;
  end
  assign rel_base = pc_q + {13'h0000, result.length} + {{8{result.data[7]}}, result.data};
  sequence s_take; ready && start; endsequence
  sequence s_first; mem_req && mem_addr == $past(start_pc); endsequence
  sequence s_finish; done || illegal_reset; endsequence
  property p_start_fetch; s_take |=> s_first; endproperty
  a_start_fetch: assert property (p_start_fetch) else $error("first fetch misplaced");
  property p_bound; s_take |-> ##[2:80] s_finish; endproperty
  a_bound: assert property (p_bound) else $error("decode never finished");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("fetch request dropped");
  property p_short_ix;
    done && result.mode inside {amd_pkg::AM_IX_S, amd_pkg::AM_IIX_S} |-> result.ea <= 16'h01fe;
  endproperty
  a_short_ix: assert property (p_short_ix) else $error("short indexed reach");
  property p_page0;
    done && result.mode inside {amd_pkg::AM_IND_S, amd_pkg::AM_DIR_S} |-> result.ea[15:8] == 8'h00;
  endproperty
  a_page0: assert property (p_page0) else $error("short address off page zero");
  property p_rel;
    done && result.mode inside {amd_pkg::AM_REL_D, amd_pkg::AM_REL_I} |-> result.target == rel_base;
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_len; done && result.prebyte != 8'h00 |-> result.length inside {[3'h2:3'h4]}; endproperty
  a_len: assert property (p_len) else $error("prefixed length wrong");
  property p_pre;
    done |-> result.prebyte inside {8'h00, 8'h90, 8'h91, 8'h92};
  endproperty
  a_pre: assert property (p_pre) else $error("unknown prebyte kept");
  property p_y90;
    done && result.prebyte == 8'h90 && result.mode inside {amd_pkg::AM_IX0, amd_pkg::AM_IX_S,
      amd_pkg::AM_IX_L} |-> result.use_y;
  endproperty
  a_y90: assert property (p_y90) else $error("second index not chosen");
  property p_y91;
    done && result.prebyte == 8'h91 && result.mode inside {amd_pkg::AM_IIX_S, amd_pkg::AM_IIX_L}
      |-> result.use_y;
  endproperty
  a_y91: assert property (p_y91) else $error("second index not chosen");
  property p_ill; illegal_reset |-> !done && ready ##1 !illegal_reset; endproperty
  a_ill: assert property (p_ill) else $error("illegal pulse wrong");
endmodule

bind amd_decoder amd_decoder_sva i_amd_decoder_sva (.mclk(mclk), .resetn(resetn),
  .start(start), .start_pc(start_pc), .index_x(index_x), .index_y(index_y), .ready(ready),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .done(done), .result(result), .illegal_reset(illegal_reset));

// *** amd_mem_model.sv ***
/*
  Behavioural byte memory that answers the decoder's fetches.
  Assumes the testbench writes the store directly and sets the stall count while idle.
*/
module amd_mem_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [1:0]  stall,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [0:65535];
  logic [1:0] wait_q;
  logic [7:0] last_q;
  assign mem_ack = mem_req && (wait_q == stall);
  // Outside an answer the bus shows the inverse, so stale data never looks right.
  assign mem_rdata = mem_ack ? store[mem_addr] : ~last_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 2'h0;
      last_q <= 8'h00;
    end else if (mem_ack) begin
      wait_q <= 2'h0;
      last_q <= mem_rdata;
    end else if (mem_req) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// *** amd_decoder_tb_top.sv ***
/*
  Self-checking testbench for the addressing mode and prebyte decoder.
  Assumes the memory model of this folder and the bound port checker.
*/
module amd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 mclk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 start = 1'b0;
  logic [15:0]          start_pc = 16'h0000;
  logic [7:0]           index_x = 8'h00;
  logic [7:0]           index_y = 8'h00;
  logic [1:0]           stall = 2'h0;
  logic                 ready, mem_req, mem_ack, done, illegal_reset, ill;
  logic [15:0]          mem_addr;
  logic [7:0]           mem_rdata;
  amd_pkg::amd_result_t result;
  int                   err_count = 0;
  int                   checked = 0;
  initial forever #20 mclk = ~mclk;
  amd_decoder i_amd_decoder (.mclk(mclk), .resetn(resetn), .start(start), .start_pc(start_pc),
    .index_x(index_x), .index_y(index_y), .ready(ready), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done), .result(result),
    .illegal_reset(illegal_reset));
  amd_mem_model i_amd_mem_model (.mclk(mclk), .resetn(resetn), .stall(stall), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic put4(input logic [15:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) i_amd_mem_model.store[a + i] = w[31 - 8 * i -: 8];
  endtask
  task automatic decode(input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y);
    int n;
    n = 0;
    check("ready", ready, 1'b1);
    start = 1'b1;
    start_pc = pc;
    index_x = x;
    index_y = y;
    @(posedge mclk);
    #1;
    start = 1'b0;
    while (done !== 1'b1 && illegal_reset !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("finished", n < 100, 1'b1);
    ill = illegal_reset;
  endtask
  task automatic res(input logic [4:0] m, input logic [2:0] len, input logic y,
                     input logic [15:0] a, input logic tgt);
    check("ill", ill, 1'b0);
    check("mode", result.mode, m);
    check("length", result.length, len);
    check("use_y", result.use_y, y);
    check("address", tgt ? result.target : result.ea, a);
  endtask
  task automatic t_indexed;
    stall = 2'h0;
    put4(16'h0100, 32'he6ff0000);
    decode(16'h0100, 8'hff, 8'h00);
    res(amd_pkg::AM_IX_S, 3'h2, 1'b0, 16'h01fe, 1'b0);
    stall = 2'h2;
    put4(16'h0200, 32'h90d61234);
    decode(16'h0200, 8'h05, 8'h10);
    res(amd_pkg::AM_IX_L, 3'h4, 1'b1, 16'h1244, 1'b0);
    check("prebyte", result.prebyte, 8'h90);
    $display("test indexed done");
  endtask
  task automatic t_indirect;
    stall = 2'h1;
    put4(16'h0300, 32'h92b64000);
    put4(16'h0040, 32'h80000000);
    decode(16'h0300, 8'h00, 8'h00);
    res(amd_pkg::AM_IND_S, 3'h3, 1'b0, 16'h0080, 1'b0);
    put4(16'h0400, 32'h92c65000);
    put4(16'h0050, 32'h12340000);
    decode(16'h0400, 8'h00, 8'h00);
    res(amd_pkg::AM_IND_L, 3'h3, 1'b0, 16'h1234, 1'b0);
    put4(16'h0500, 32'h91e66000);
    put4(16'h0060, 32'hff000000);
    decode(16'h0500, 8'h01, 8'hff);
    res(amd_pkg::AM_IIX_S, 3'h3, 1'b1, 16'h01fe, 1'b0);
    put4(16'h0600, 32'h92d67000);
    put4(16'h0070, 32'h12f00000);
    decode(16'h0600, 8'h20, 8'h00);
    res(amd_pkg::AM_IIX_L, 3'h3, 1'b0, 16'h1310, 1'b0);
    $display("test indirect done");
  endtask
  task automatic t_relative;
    stall = 2'h0;
    put4(16'h0700, 32'h27800000);
    decode(16'h0700, 8'h00, 8'h00);
    res(amd_pkg::AM_REL_D, 3'h2, 1'b0, 16'h0682, 1'b1);
    check("offset", result.data, 8'h80);
    put4(16'h0800, 32'h92274400);
    put4(16'h0044, 32'h7f000000);
    decode(16'h0800, 8'h00, 8'h00);
    res(amd_pkg::AM_REL_I, 3'h3, 1'b0, 16'h0882, 1'b1);
    put4(16'h0900, 32'had050000);
    decode(16'h0900, 8'h00, 8'h00);
    res(amd_pkg::AM_REL_D, 3'h2, 1'b0, 16'h0907, 1'b1);
    $display("test relative done");
  endtask
  task automatic t_forms;
    stall = 2'h1;
    put4(16'h0a00, 32'h31000000);
    decode(16'h0a00, 8'h00, 8'h00);
    check("illegal", ill, 1'b1);
    check("done", done, 1'b0);
    put4(16'h0b00, 32'h91b62000);
    decode(16'h0b00, 8'h00, 8'h00);
    res(amd_pkg::AM_DIR_S, 3'h3, 1'b0, 16'h0020, 1'b0);
    check("unauth", result.unauth, 1'b1);
    put4(16'h0c00, 32'h90920000);
    decode(16'h0c00, 8'h00, 8'h00);
    check("prebyte", result.prebyte, 8'h90);
    check("opcode", result.opcode, 8'h92);
    check("use_y", result.use_y, 1'b1);
    put4(16'h0d00, 32'h3a100000);
    decode(16'h0d00, 8'h00, 8'h00);
    res(amd_pkg::AM_DIR_S, 3'h2, 1'b0, 16'h0010, 1'b0);
    put4(16'h0e00, 32'hc6123400);
    decode(16'h0e00, 8'h00, 8'h00);
    res(amd_pkg::AM_DIR_L, 3'h3, 1'b0, 16'h1234, 1'b0);
    check("prebyte", result.prebyte, 8'h00);
    $display("test forms done");
  endtask
  task automatic t_bits;
    stall = 2'h2;
    put4(16'h0f00, 32'h92004005);
    put4(16'h0040, 32'h12000000);
    decode(16'h0f00, 8'h00, 8'h00);
    res(amd_pkg::AM_BTJ_I, 3'h4, 1'b0, 16'h0012, 1'b0);
    check("target", result.target, 16'h0f09);
    put4(16'h1000, 32'ha6550000);
    decode(16'h1000, 8'h00, 8'h00);
    res(amd_pkg::AM_IMM, 3'h2, 1'b0, 16'h1001, 1'b0);
    check("data", result.data, 8'h55);
    $display("test bits done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #40000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    check("reset req", mem_req, 1'b0);
    check("reset result", result == '0, 1'b1);
    resetn = 1'b1;
    t_indexed();
    t_indirect();
    t_relative();
    t_forms();
    t_bits();
    close_out();
  end
endmodule
